// file: rtl/pmw_map.svh
// Register offsets, field positions and timing counts of the power block
`ifndef PMW_MAP_SVH
`define PMW_MAP_SVH
// Register indices; byte address is four times the index
`define PMW_IDX_PWR 8'hA5
`define PMW_IDX_SVC 8'hA6
`define PMW_IDX_PRG 8'hA7
// Power control fields
`define PMW_PWR_IDLE 0
`define PMW_PWR_DOWN 1
`define PMW_PWR_GFA 2
`define PMW_PWR_GFB 3
`define PMW_PWR_WDT 4
`define PMW_PWR_ARM 5
// Timeout program select field
`define PMW_PRG_SEL_LO 0
`define PMW_PRG_SEL_HI 2
`define PMW_PRG_RST 8'h00
// Unlock bytes
`define PMW_KEY_A 8'h1E
`define PMW_KEY_B 8'hE1
// Watchdog limits
`define PMW_WDT_MAX 14'h3FFF
`define PMW_PRE_ALL 7'h7F
// Clock is the oscillator: one clk period per oscillator period
`define PMW_CLK_MHZ 50
`define PMW_MC_TOSC 12
`define PMW_MC_CYC (`PMW_MC_TOSC)
`define PMW_MC_LAST 4'(`PMW_MC_CYC - 1)
`define PMW_PULSE_TOSC 96
`define PMW_PULSE_CYC 7'(`PMW_PULSE_TOSC)
`endif

// file: rtl/pmw_pkg.sv
// Types of the power mode and watchdog block
package pmw_pkg;
  typedef enum logic [1:0] {PMW_RUN, PMW_IDLE, PMW_DOWN, PMW_WAKE} pmw_mode_t;
  typedef struct packed {
    pmw_mode_t mode;
    logic gf_a;
    logic gf_b;
    logic [3:0] mc;
    logic [6:0] pre;
    logic [13:0] wdt;
    logic wdt_on;
    logic armed;
    logic [7:0] prg;
    logic [6:0] pulse;
    logic [1:0] low_seen;
    logic ack;
    logic [7:0] rdat;
    logic cpu_clk_en;
    logic osc_run;
    logic strobe_hold;
    logic rst_pulse;
    logic wake;
  } pmw_state_t;
endpackage

// file: rtl/pmw_top.sv
// Power modes and watchdog with a classic Wishbone register slave
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pmw_map.svh"

module pmw_top
  import pmw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic irq_pending_i,
  input wire logic ext_a_en_i,
  input wire logic ext_b_en_i,
  input wire logic ext_a_n_i,
  input wire logic ext_b_n_i,
  output logic cpu_clk_en_o,
  output logic osc_run_o,
  output logic strobe_hold_o,
  output logic wake_o,
  output logic rst_pulse_o
);

  // ************************************************************
  // State and decode
  // ************************************************************
  pmw_state_t s;
  pmw_state_t next_s;
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic mc_tick;
  logic [6:0] mask;
  logic wdt_tick;
  logic [1:0] ext_low;
  logic [1:0] ext_high;

  assign idx = wb_adr_i[9:2];
  assign wbyte = wb_dat_i[7:0];
  assign req = wb_cyc_i && wb_stb_i && !s.ack;
  assign wr = wb_cyc_i && wb_stb_i && s.ack && wb_we_i && wb_sel_i[0];
  assign mc_tick = s.osc_run && (s.mc == `PMW_MC_LAST);
  assign mask = ~(`PMW_PRE_ALL << s.prg[`PMW_PRG_SEL_HI:`PMW_PRG_SEL_LO]);
  assign wdt_tick = s.wdt_on && mc_tick && ((s.pre & mask) == mask);
  assign ext_low = {ext_b_en_i && !ext_b_n_i, ext_a_en_i && !ext_a_n_i};
  assign ext_high = {ext_b_n_i, ext_a_n_i};

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    next_s = s;
    next_s.ack = req;
    next_s.wake = 1'b0;
    // Read data; service register reads zero
    next_s.rdat = 8'h00;
    if (req && !wb_we_i)
    begin
      if (idx == `PMW_IDX_PWR)
      begin
        next_s.rdat[`PMW_PWR_IDLE] = (s.mode == PMW_IDLE);
        next_s.rdat[`PMW_PWR_DOWN] = (s.mode == PMW_DOWN) || (s.mode == PMW_WAKE);
        next_s.rdat[`PMW_PWR_GFA] = s.gf_a;
        next_s.rdat[`PMW_PWR_GFB] = s.gf_b;
        next_s.rdat[`PMW_PWR_WDT] = s.wdt_on;
        next_s.rdat[`PMW_PWR_ARM] = s.armed;
      end
      else if (idx == `PMW_IDX_PRG)
      begin
        next_s.rdat = s.prg;
      end
    end
    // Machine cycle divider, frozen while oscillator is stopped
    if (s.osc_run)
    begin
      next_s.mc = mc_tick ? 4'h0 : s.mc + 4'h1;
    end
    // Prescaler and watchdog counter
    if (s.wdt_on && mc_tick)
    begin
      next_s.pre = s.pre + 7'h01;
    end
    if (wdt_tick)
    begin
      next_s.wdt = s.wdt + 14'h0001;
    end
    // Overflow: disable and start reset pulse
    if (s.wdt_on && s.wdt == `PMW_WDT_MAX)
    begin
      next_s.wdt_on = 1'b0;
      next_s.wdt = 14'h0000;
      next_s.pre = 7'h00;
      next_s.rst_pulse = 1'b1;
      next_s.pulse = `PMW_PULSE_CYC;
    end
    else if (s.pulse != 7'h00)
    begin
      next_s.pulse = s.pulse - 7'h01;
      next_s.rst_pulse = (s.pulse != 7'h01);
    end
    // Register writes take effect at the edge that ends the ack cycle, one clock after ack rises
    if (wr)
    begin
      if (idx == `PMW_IDX_PWR)
      begin
        next_s.gf_a = wbyte[`PMW_PWR_GFA];
        next_s.gf_b = wbyte[`PMW_PWR_GFB];
        if (wbyte[`PMW_PWR_DOWN])
        begin
          next_s.mode = PMW_DOWN;
        end
        else if (wbyte[`PMW_PWR_IDLE])
        begin
          next_s.mode = PMW_IDLE;
        end
      end
      else if (idx == `PMW_IDX_SVC)
      begin
        // Two-byte unlock and service sequence
        if (wbyte == `PMW_KEY_A)
        begin
          next_s.armed = 1'b1;
        end
        else if (wbyte == `PMW_KEY_B && s.armed)
        begin
          next_s.armed = 1'b0;
          next_s.wdt_on = 1'b1;
          next_s.wdt = 14'h0000;
          next_s.pre = 7'h00;
        end
        else
        begin
          next_s.armed = 1'b0;
        end
      end
      else if (idx == `PMW_IDX_PRG)
      begin
        next_s.prg = wbyte;
      end
    end
    else if (wb_cyc_i && wb_stb_i && s.ack && wb_we_i && idx != `PMW_IDX_SVC)
    begin
      next_s.armed = s.armed;
    end
    // Low-power mode sequencing
    unique case (s.mode)
      PMW_RUN:
      begin
        next_s.low_seen = 2'b00;
      end
      PMW_IDLE:
      begin
        // Enabled interrupt clears idle and wakes the CPU
        if (irq_pending_i)
        begin
          next_s.mode = PMW_RUN;
          next_s.wake = 1'b1;
        end
      end
      PMW_DOWN:
      begin
        // Only an enabled external input low, or a power register write setting idle without down, restarts the oscillator
        if (ext_low != 2'b00)
        begin
          next_s.mode = PMW_WAKE;
          next_s.low_seen = ext_low;
        end
      end
      PMW_WAKE:
      begin
        // First released input completes the exit
        next_s.low_seen = s.low_seen | ext_low;
        if ((s.low_seen & ext_high) != 2'b00)
        begin
          next_s.mode = PMW_RUN;
          next_s.wake = 1'b1;
        end
      end
    endcase
    // Clock gating: CPU clock stops, peripheral clock continues in idle
    next_s.cpu_clk_en = (next_s.mode == PMW_RUN);
    next_s.osc_run = (next_s.mode != PMW_DOWN);
    next_s.strobe_hold = (next_s.mode != PMW_RUN);
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.mode <= PMW_RUN;
      s.prg <= `PMW_PRG_RST;
      s.cpu_clk_en <= 1'b1;
      s.osc_run <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = {24'h000000, s.rdat};
  assign cpu_clk_en_o = s.cpu_clk_en;
  assign osc_run_o = s.osc_run;
  assign strobe_hold_o = s.strobe_hold;
  assign wake_o = s.wake;
  assign rst_pulse_o = s.rst_pulse;

  // ************************************************************
  // Checks
  // ************************************************************
  logic [7:0] pulse_len;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pulse_len <= 8'h00;
    end
    else if (rst_pulse_o)
    begin
      pulse_len <= pulse_len + 8'h01;
    end
    else
    begin
      pulse_len <= 8'h00;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  wb_answer_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus request not acknowledged in one cycle");
  idle_gate_a: assert property (s.mode == PMW_IDLE |-> !cpu_clk_en_o && osc_run_o)
    else $error("idle clock gating wrong");
  strobe_hold_a: assert property (s.mode != PMW_RUN |-> strobe_hold_o)
    else $error("strobes not held high");
  idle_wake_a: assert property (s.mode == PMW_IDLE && irq_pending_i |=> cpu_clk_en_o && wake_o)
    else $error("idle not ended by interrupt");
  idle_enter_a: assert property (wr && idx == `PMW_IDX_PWR && wbyte[1:0] == 2'b01
    |=> s.mode == PMW_IDLE ##1 !cpu_clk_en_o || $past(irq_pending_i))
    else $error("idle not entered after write");
  down_osc_a: assert property (s.mode == PMW_DOWN && $past(s.mode) == PMW_DOWN
    |-> !osc_run_o && $stable(s.wdt))
    else $error("oscillator running in power-down");
  down_hold_a: assert property (s.mode == PMW_DOWN && ext_low == 2'b00 && !wr
    |=> s.mode == PMW_DOWN)
    else $error("power-down left without wake source");
  wdt_enable_a: assert property ($rose(s.wdt_on) |-> $past(s.armed) && $past(wbyte) == `PMW_KEY_B)
    else $error("watchdog enabled without unlock");
  seq_abandon_a: assert property (wr && idx == `PMW_IDX_SVC && wbyte != `PMW_KEY_A
    && wbyte != `PMW_KEY_B |=> !s.armed && s.wdt_on == $past(s.wdt_on))
    else $error("bad byte did not abandon unlock");
  wdt_count_a: assert property (wdt_tick && s.wdt != `PMW_WDT_MAX && !wr
    |=> s.wdt == $past(s.wdt) + 14'h0001)
    else $error("watchdog did not count");
  pulse_len_a: assert property ($fell(rst_pulse_o) |-> pulse_len == 8'h60)
    else $error("reset pulse length wrong");

  // ************************************************************
  // Bus and register checks
  // ************************************************************
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside ack");
  dat_high_a: assert property (wb_dat_o[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  svc_read_a: assert property (req && !wb_we_i && idx == `PMW_IDX_SVC
    |=> wb_dat_o == 32'h00000000)
    else $error("service register readable");
  prg_read_a: assert property (req && !wb_we_i && idx == `PMW_IDX_PRG
    |=> wb_dat_o[7:0] == $past(s.prg))
    else $error("timeout program read wrong");
  prg_write_a: assert property (wr && idx == `PMW_IDX_PRG
    |=> s.prg == $past(wbyte))
    else $error("timeout program write lost");
  flag_write_a: assert property (wr && idx == `PMW_IDX_PWR |=> s.gf_a == $past(wbyte[`PMW_PWR_GFA])
    && s.gf_b == $past(wbyte[`PMW_PWR_GFB]))
    else $error("general flag write lost");
  flag_read_a: assert property (req && !wb_we_i && idx == `PMW_IDX_PWR
    |=> wb_dat_o[`PMW_PWR_GFA] == $past(s.gf_a) && wb_dat_o[`PMW_PWR_GFB] == $past(s.gf_b))
    else $error("general flag read wrong");

  // ************************************************************
  // Mode checks
  // ************************************************************
  run_clock_a: assert property (s.mode == PMW_RUN
    |-> cpu_clk_en_o && osc_run_o && !strobe_hold_o)
    else $error("run mode outputs wrong");
  idle_stay_a: assert property (s.mode == PMW_IDLE && !irq_pending_i && !wr
    |=> s.mode == PMW_IDLE && !cpu_clk_en_o)
    else $error("idle left without interrupt");
  down_enter_a: assert property (wr && idx == `PMW_IDX_PWR && wbyte[`PMW_PWR_DOWN]
    && s.mode == PMW_RUN |=> s.mode == PMW_DOWN && !osc_run_o && !cpu_clk_en_o)
    else $error("power-down not entered after write");
  down_cpu_a: assert property (s.mode == PMW_DOWN
    |-> !cpu_clk_en_o && strobe_hold_o)
    else $error("power-down outputs wrong");
  down_restart_a: assert property (s.mode == PMW_DOWN && ext_low != 2'b00
    |=> s.mode == PMW_WAKE && osc_run_o)
    else $error("oscillator not restarted by wake input");
  wake_clock_a: assert property (s.mode == PMW_WAKE
    |-> osc_run_o && !cpu_clk_en_o)
    else $error("restart phase outputs wrong");
  wake_wait_a: assert property (s.mode == PMW_WAKE && (s.low_seen & ext_high) == 2'b00
    && !wr |=> s.mode == PMW_WAKE)
    else $error("power-down exit before release");
  wake_exit_a: assert property (s.mode == PMW_WAKE && (s.low_seen & ext_high) != 2'b00
    |=> s.mode == PMW_RUN && cpu_clk_en_o && wake_o)
    else $error("release did not complete exit");
  wake_pulse_a: assert property (wake_o |=> !wake_o)
    else $error("wake pulse longer than one cycle");
  wake_source_a: assert property ($rose(wake_o) |-> $past(s.mode) != PMW_RUN)
    else $error("wake pulse without low-power mode");

  // ************************************************************
  // Watchdog checks
  // ************************************************************
  wdt_rest_a: assert property (!s.wdt_on |-> s.wdt == 14'h0000)
    else $error("watchdog counter moves while off");
  wdt_freeze_a: assert property (s.wdt_on && !osc_run_o && s.wdt != `PMW_WDT_MAX && !wr
    |=> s.wdt == $past(s.wdt))
    else $error("watchdog counts with oscillator stopped");
  wdt_keep_a: assert property (s.wdt_on && s.wdt != `PMW_WDT_MAX |=> s.wdt_on)
    else $error("watchdog disabled without overflow");
  arm_set_a: assert property (wr && idx == `PMW_IDX_SVC && wbyte == `PMW_KEY_A
    |=> s.armed)
    else $error("first unlock byte not taken");
  wdt_restart_a: assert property (wr && idx == `PMW_IDX_SVC && wbyte == `PMW_KEY_B
    && s.armed |=> s.wdt_on && s.wdt == 14'h0000)
    else $error("service sequence did not restart count");
  wdt_overflow_a: assert property (s.wdt_on && s.wdt == `PMW_WDT_MAX && !wr
    |=> rst_pulse_o && !s.wdt_on)
    else $error("overflow did not start reset pulse");
  pulse_count_a: assert property (rst_pulse_o |-> pulse_len < 8'h60)
    else $error("reset pulse too long");
  pulse_idle_a: assert property (!rst_pulse_o |-> s.pulse == 7'h00)
    else $error("pulse counter running without pulse");

endmodule
`default_nettype wire

// file: verification/pmw_far.sv
// Far-side model: reset pin, external interrupt pins, CPU interrupt line
`timescale 1ns/100ps
`default_nettype none
module pmw_far (
  input wire logic por_i,
  input wire logic rst_pulse_i,
  input wire logic pull_a_i,
  input wire logic pull_b_i,
  input wire logic irq_i,
  output logic rst_o,
  output logic ext_a_n_o,
  output logic ext_b_n_o,
  output logic irq_pending_o
);
  // Watchdog pulse loops back onto the reset pin
  assign rst_o = por_i | rst_pulse_i;
  // Released pins rest at the pull-up level
  assign ext_a_n_o = ~pull_a_i;
  assign ext_b_n_o = ~pull_b_i;
  assign irq_pending_o = irq_i;
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench of the power mode and watchdog block
`timescale 1ns/100ps
`default_nettype none
`include "pmw_map.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
`define WAIT(c) begin k = 0; while ((c) !== 1'b1 && k < 3000) \
  begin @(posedge clk_i); k++; end \
  if ((c) !== 1'b1) begin fails++; test_done(); end end
module tb;
  logic clk_i = 0, por = 1, cyc = 0, stb = 0, we = 0, irq = 0;
  logic pull_a = 0, pull_b = 0, en_a = 0, en_b = 0;
  logic [9:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rdat;
  wire logic rst, xa_n, xb_n, irq_p, ack, cke, osc, hold, wake, rpl;
  wire logic [31:0] dato;
  int fails = 0, checks = 0, k;
  always #10 clk_i = ~clk_i;
  pmw_top i_pmw_top (.clk_i(clk_i), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato),
    .wb_ack_o(ack), .irq_pending_i(irq_p), .ext_a_en_i(en_a), .ext_b_en_i(en_b),
    .ext_a_n_i(xa_n), .ext_b_n_i(xb_n), .cpu_clk_en_o(cke), .osc_run_o(osc),
    .strobe_hold_o(hold), .wake_o(wake), .rst_pulse_o(rpl));
  pmw_far i_pmw_far (.por_i(por), .rst_pulse_i(rpl), .pull_a_i(pull_a),
    .pull_b_i(pull_b), .irq_i(irq), .rst_o(rst), .ext_a_n_o(xa_n),
    .ext_b_n_o(xb_n), .irq_pending_o(irq_p));
  // ****************
  // Tasks
  // ****************
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    wdat <= {24'h000000, d};
    `WAIT(ack)
    rdat = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic t_regs();
    bus(1'b0, `PMW_IDX_PWR, 8'h00);
    `CHK("pwr", 32'h0, rdat)
    bus(1'b0, `PMW_IDX_PRG, 8'h00);
    `CHK("prg reset", 32'h0, rdat)
    bus(1'b1, `PMW_IDX_PRG, 8'h07);
    bus(1'b0, `PMW_IDX_PRG, 8'h00);
    `CHK("prg", 32'h7, rdat)
    bus(1'b1, `PMW_IDX_SVC, 8'h5A);
    bus(1'b0, `PMW_IDX_SVC, 8'h00);
    `CHK("svc", 32'h0, rdat)
    bus(1'b0, 8'h10, 8'h00);
    `CHK("unmapped", 32'h0, rdat)
    bus(1'b1, `PMW_IDX_PRG, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_idle();
    bus(1'b1, `PMW_IDX_PWR, 8'h0D);
    `WAIT(!cke)
    `CHK("hold", 1'b1, hold)
    `CHK("osc", 1'b1, osc)
    repeat (5) @(posedge clk_i);
    `CHK("idle cke", 1'b0, cke)
    irq <= 1'b1;
    `WAIT(wake)
    `CHK("wake cke", 1'b1, cke)
    irq <= 1'b0;
    bus(1'b0, `PMW_IDX_PWR, 8'h00);
    `CHK("flags", 32'hC, rdat)
    $display("test idle done");
  endtask
  task automatic t_down();
    bus(1'b1, `PMW_IDX_PWR, 8'h02);
    `WAIT(!osc)
    `CHK("down cke", 1'b0, cke)
    irq <= 1'b1;
    pull_a <= 1'b1;
    repeat (20) @(posedge clk_i);
    `CHK("osc stays off", 1'b0, osc)
    irq <= 1'b0;
    pull_a <= 1'b0;
    en_a <= 1'b1;
    en_b <= 1'b1;
    pull_b <= 1'b1;
    `WAIT(osc)
    `CHK("restart cke", 1'b0, cke)
    pull_a <= 1'b1;
    repeat (5) @(posedge clk_i);
    pull_a <= 1'b0;
    `WAIT(wake)
    `CHK("exit cke", 1'b1, cke)
    pull_b <= 1'b0;
    $display("test down done");
  endtask
  task automatic t_wdt();
    bus(1'b1, `PMW_IDX_SVC, `PMW_KEY_A);
    bus(1'b1, `PMW_IDX_SVC, 8'h55);
    bus(1'b1, `PMW_IDX_SVC, `PMW_KEY_B);
    bus(1'b0, `PMW_IDX_PWR, 8'h00);
    `CHK("wdt abandon", 1'b0, rdat[4])
    bus(1'b1, `PMW_IDX_SVC, `PMW_KEY_A);
    bus(1'b1, `PMW_IDX_SVC, `PMW_KEY_B);
    bus(1'b0, `PMW_IDX_PWR, 8'h00);
    `CHK("wdt on", 1'b1, rdat[4])
    repeat (2000) @(posedge clk_i);
    `CHK("no pulse", 1'b0, rpl)
    por <= 1'b1;
    repeat (24) @(posedge clk_i);
    por <= 1'b0;
    bus(1'b0, `PMW_IDX_PWR, 8'h00);
    `CHK("wdt off", 1'b0, rdat[4])
    $display("test wdt done");
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    por <= 1'b0;
    t_regs();
    t_idle();
    t_down();
    t_wdt();
    test_done();
  end
endmodule
`default_nettype wire
